// ==== src/twowire_map.svh ====
// Address map, bit positions and reset values of the two-wire block.
// Assumes the core's special-function bus uses 8-bit addresses.
`ifndef TWOWIRE_MAP_SVH
`define TWOWIRE_MAP_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define TW_DATA_ADDR 8'h9a
`define TW_SADDR_ADDR 8'h9b
`define TW_CTRL_ADDR 8'he8

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TW_DATA_RST 8'h00
`define TW_SADDR_RST 8'h55
`define TW_CTRL_RST 8'h00
`define TW_READ_IDLE 8'h00

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define TW_BIT_DATA_OUT 7
`define TW_BIT_DATA_EN 6
`define TW_BIT_CLK_OUT 5
`define TW_BIT_DATA_IN 4
`define TW_BIT_ROLE 3
`define TW_BIT_SRST 2
`define TW_BIT_DIR 1
`define TW_BIT_DONE 0

// ------------------------------------------------------------
// Byte framing
// ------------------------------------------------------------
`define TW_BITS_PER_BYTE 4'd8
`define TW_CNT_ZERO 4'd0
`define TW_CNT_ONE 4'd1

`endif

// ==== src/twowire_pkg.sv ====
// Types shared by the two-wire block.
// Assumes nothing beyond a SystemVerilog compiler.
package twowire_pkg;

   // ------------------------------------------------------------
   // Slave byte engine states
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ADDR = 7'b0000010,
      ST_AACK = 7'b0000100,
      ST_RX = 7'b0001000,
      ST_RACK = 7'b0010000,
      ST_TX = 7'b0100000,
      ST_TACK = 7'b1000000
   } slave_state_t;

endpackage : twowire_pkg

// ==== src/pin_sync.sv ====
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk, // Core clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic async_in, // Level from a pin
   output logic sync_out // Level safe to use in clk domain
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule : pin_sync

// ==== src/twowire_core.sv ====
// Two-wire serial block: software-driven master or hardware slave.
// Assumes an 8-bit register port at the core clock and pins that
// are resolved outside (value, enable). Pins pass a synchroniser.
`timescale 1ns/1ps
`include "twowire_map.svh"
module twowire_core
   import twowire_pkg::*;
(
   input wire logic clk, // Core clock, 25 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [7:0] sfr_addr, // Register address
   input wire logic sfr_wr, // Write strobe, one cycle
   input wire logic sfr_rd, // Read strobe, one cycle
   input wire logic [7:0] sfr_wdata, // Write data
   output logic [7:0] sfr_rdata, // Read data, valid cycle after strobe
   input wire logic spi_select_bit, // SPI owns the pins when high
   input wire logic serial_data_pin_in, // Data pin level
   output logic serial_data_pin_out, // Data pin drive value
   output logic serial_data_pin_oe, // Data pin drive enable
   input wire logic serial_clock_pin_in, // Clock pin level
   output logic serial_clock_pin_out, // Clock pin drive value
   output logic serial_clock_pin_oe // Clock pin drive enable
);
   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   logic sda_s;
   logic scl_s;
   logic sda_q_reg;
   logic scl_q_reg;

   pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
      .clk(clk),
      .rst(rst),
      .async_in(serial_data_pin_in),
      .sync_out(sda_s)
   );

   pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
      .clk(clk),
      .rst(rst),
      .async_in(serial_clock_pin_in),
      .sync_out(scl_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         sda_q_reg <= 1'b1;
         scl_q_reg <= 1'b1;
      end else begin
         sda_q_reg <= sda_s;
         scl_q_reg <= scl_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise = scl_s & ~scl_q_reg;
   assign scl_fall = ~scl_s & scl_q_reg;
   assign start_cond = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   assign stop_cond = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

   // ------------------------------------------------------------
   // Registers and control state
   // ------------------------------------------------------------
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] saddr_reg, saddr_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] rx_reg, rx_next;
   logic [7:0] rdata_reg, rdata_next;
   slave_state_t state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [3:0] cnt_reg, cnt_next;
   logic drive_low_reg, drive_low_next;
   logic dir_reg, dir_next;
   logic byte_done;

   logic role_master;
   logic slave_run;
   logic ctrl_wr;
   assign role_master = ctrl_reg[`TW_BIT_ROLE];
   assign ctrl_wr = sfr_wr && (sfr_addr == `TW_CTRL_ADDR);
   assign slave_run = ~role_master & ~ctrl_reg[`TW_BIT_SRST] & ~spi_select_bit;

   // ------------------------------------------------------------
   // Slave byte engine
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      drive_low_next = drive_low_reg;
      dir_next = dir_reg;
      rx_next = rx_reg;
      byte_done = 1'b0;
      if (!slave_run) begin
         state_next = ST_IDLE;
         drive_low_next = 1'b0;
         cnt_next = `TW_CNT_ZERO;
      end else if (start_cond) begin
         state_next = ST_ADDR;
         dir_next = 1'b0;
         drive_low_next = 1'b0;
         cnt_next = `TW_CNT_ZERO;
      end else if (stop_cond) begin
         state_next = ST_IDLE;
         drive_low_next = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next = cnt_reg + `TW_CNT_ONE;
               end else if (scl_fall && cnt_reg == `TW_BITS_PER_BYTE) begin
                  cnt_next = `TW_CNT_ZERO;
                  if (state_reg == ST_RX) begin
                     rx_next = shift_reg;
                     byte_done = 1'b1;
                     state_next = ST_RACK;
                     drive_low_next = 1'b1;
                  end else if (shift_reg[7:1] == saddr_reg[6:0]) begin
                     state_next = ST_AACK;
                     drive_low_next = 1'b1;
                     dir_next = shift_reg[0];
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_AACK, ST_RACK: begin
               if (scl_fall) begin
                  if (dir_reg) begin
                     state_next = ST_TX;
                     shift_next = tx_reg;
                     drive_low_next = ~tx_reg[7];
                  end else begin
                     state_next = ST_RX;
                     drive_low_next = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + `TW_CNT_ONE;
               end else if (scl_fall) begin
                  if (cnt_reg == `TW_BITS_PER_BYTE) begin
                     byte_done = 1'b1;
                     cnt_next = `TW_CNT_ZERO;
                     state_next = ST_TACK;
                     drive_low_next = 1'b0;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_low_next = ~shift_reg[6];
                  end
               end
            end
            ST_TACK: begin
               // Master's not-acknowledge ends the read
               if (scl_rise && sda_s) begin
                  state_next = ST_IDLE;
               end else if (scl_fall) begin
                  state_next = ST_TX;
                  shift_next = tx_reg;
                  drive_low_next = ~tx_reg[7];
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         shift_reg <= 8'h00;
         cnt_reg <= `TW_CNT_ZERO;
         drive_low_reg <= 1'b0;
         dir_reg <= 1'b0;
         rx_reg <= `TW_DATA_RST;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         drive_low_reg <= drive_low_next;
         dir_reg <= dir_next;
         rx_reg <= rx_next;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_comb begin
      ctrl_next = ctrl_reg;
      saddr_next = saddr_reg;
      tx_next = tx_reg;
      rdata_next = rdata_reg;
      if (ctrl_wr) begin
         ctrl_next[7:5] = sfr_wdata[7:5];
         ctrl_next[`TW_BIT_ROLE] = sfr_wdata[`TW_BIT_ROLE];
         ctrl_next[`TW_BIT_SRST] = sfr_wdata[`TW_BIT_SRST];
         ctrl_next[`TW_BIT_DONE] = sfr_wdata[`TW_BIT_DONE];
      end
      if (sfr_wr && sfr_addr == `TW_SADDR_ADDR) begin
         saddr_next = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == `TW_DATA_ADDR) begin
         tx_next = sfr_wdata;
      end
      if (role_master && !ctrl_reg[`TW_BIT_DATA_EN] && scl_rise) begin
         ctrl_next[`TW_BIT_DATA_IN] = sda_s;
      end
      ctrl_next[`TW_BIT_DIR] = dir_reg & slave_run & (state_reg != ST_IDLE);
      if (byte_done) begin
         ctrl_next[`TW_BIT_DONE] = 1'b1;
      end
      if (sfr_rd) begin
         if (sfr_addr == `TW_CTRL_ADDR) begin
            rdata_next = ctrl_reg;
         end else if (sfr_addr == `TW_SADDR_ADDR) begin
            rdata_next = saddr_reg;
         end else if (sfr_addr == `TW_DATA_ADDR) begin
            rdata_next = rx_reg;
         end else begin
            rdata_next = `TW_READ_IDLE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= `TW_CTRL_RST;
         saddr_reg <= `TW_SADDR_RST;
         tx_reg <= `TW_DATA_RST;
         rdata_reg <= `TW_READ_IDLE;
      end else begin
         ctrl_reg <= ctrl_next;
         saddr_reg <= saddr_next;
         tx_reg <= tx_next;
         rdata_reg <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   // SPI takes the pins
   always_comb begin
      serial_data_pin_out = 1'b0;
      serial_data_pin_oe = 1'b0;
      serial_clock_pin_out = 1'b1;
      serial_clock_pin_oe = 1'b0;
      if (!spi_select_bit) begin
         if (role_master) begin
            serial_data_pin_out = ctrl_reg[`TW_BIT_DATA_OUT];
            serial_data_pin_oe = ctrl_reg[`TW_BIT_DATA_EN];
            serial_clock_pin_out = ctrl_reg[`TW_BIT_CLK_OUT];
            serial_clock_pin_oe = 1'b1;
         end else begin
            // Open-drain: slave only pulls low
            serial_data_pin_oe = drive_low_reg & slave_run;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence rx_byte_end;
      state_reg == ST_RX && slave_run && !start_cond && !stop_cond && scl_fall && cnt_reg == `TW_BITS_PER_BYTE;
   endsequence

   sequence addr_byte_end;
      state_reg == ST_ADDR && slave_run && !start_cond && !stop_cond && scl_fall && cnt_reg == `TW_BITS_PER_BYTE;
   endsequence

   sequence master_ctrl_write;
      ctrl_wr && sfr_wdata[`TW_BIT_ROLE] && !spi_select_bit;
   endsequence

   a_spi_release_pins: assert property (spi_select_bit |-> !serial_data_pin_oe && !serial_clock_pin_oe)
      else $error("pins driven while SPI selected");
   a_slave_no_clock: assert property (!role_master |-> !serial_clock_pin_oe)
      else $error("slave drives the clock pin");
   a_master_data_out: assert property (master_ctrl_write ##0 (sfr_wdata[`TW_BIT_DATA_EN] && !spi_select_bit)
      |=> serial_data_pin_oe && serial_data_pin_out == $past(sfr_wdata[`TW_BIT_DATA_OUT]))
      else $error("master data bit not on pin");
   a_master_data_in: assert property (master_ctrl_write ##0 !sfr_wdata[`TW_BIT_DATA_EN] |=> !serial_data_pin_oe)
      else $error("data pin driven in receive");
   a_master_clock_out: assert property (master_ctrl_write
      |=> serial_clock_pin_out == $past(sfr_wdata[`TW_BIT_CLK_OUT]) && serial_clock_pin_oe)
      else $error("clock bit not on pin");
   a_master_sample: assert property (role_master && !ctrl_reg[`TW_BIT_DATA_EN] && !ctrl_wr && scl_rise
      |=> ctrl_reg[`TW_BIT_DATA_IN] == $past(sda_s))
      else $error("data input not latched");
   a_slave_hold_reset: assert property (!role_master && ctrl_reg[`TW_BIT_SRST] |=> state_reg == ST_IDLE
      && !serial_data_pin_oe)
      else $error("slave not held in reset");
   a_slave_direction: assert property (state_reg == ST_TX |-> ctrl_reg[`TW_BIT_DIR] || $past(state_reg) != ST_TX)
      else $error("direction flag clear while sending");
   a_byte_flag_set: assert property (rx_byte_end |=> ctrl_reg[`TW_BIT_DONE] && rx_reg == $past(shift_reg)
      ##1 serial_data_pin_oe || !slave_run)
      else $error("byte flag or data not updated");
   a_byte_flag_hold: assert property (ctrl_reg[`TW_BIT_DONE] && !ctrl_wr |=> ctrl_reg[`TW_BIT_DONE])
      else $error("byte flag dropped by itself");
   a_data_readback: assert property (sfr_rd && sfr_addr == `TW_DATA_ADDR |=> sfr_rdata == $past(rx_reg))
      else $error("data read not last received");
   a_addr_mismatch: assert property (addr_byte_end ##0 shift_reg[7:1] != saddr_reg[6:0]
      |=> state_reg == ST_IDLE && !drive_low_reg)
      else $error("answered a foreign address");
   a_reset_values: assert property (@(posedge clk) disable iff (1'b0) rst |=> ctrl_reg == `TW_CTRL_RST
      && saddr_reg == `TW_SADDR_RST)
      else $error("wrong reset values");

endmodule : twowire_core

// ==== tb/twowire_bus_master.sv ====
// Behavioural bus master standing on the far side of the two-wire pins.
// Assumes open-drain lines with pull-ups resolved by the bench; a high
// output here means the model pulls that line down.
`timescale 1ns/1ps
module twowire_bus_master (
   input wire logic sda_in, // Resolved data line
   input wire logic scl_in, // Resolved clock line
   output logic sda_low, // Pull data line low
   output logic scl_low // Pull clock line low
);
   initial begin
      sda_low = 1'b0;
      scl_low = 1'b0;
   end

   // ------------------------------------------------------------
   // Framing
   // ------------------------------------------------------------
   // Odd offset keeps the link edges off the core clock edges
   task automatic start_bit;
      #7;
      sda_low = 1'b1;
      #160 scl_low = 1'b1;
   endtask : start_bit

   task automatic stop_bit;
      #80 sda_low = 1'b1;
      #80 scl_low = 1'b0;
      #80 sda_low = 1'b0;
      #80;
   endtask : stop_bit

   task automatic hold_data(input logic b);
      sda_low = ~b;
   endtask : hold_data

   // ------------------------------------------------------------
   // Bits and bytes, MSB first
   // ------------------------------------------------------------
   task automatic put_bit(input logic b);
      #80 sda_low = ~b;
      #80 scl_low = 1'b0;
      #160 scl_low = 1'b1;
   endtask : put_bit

   // Sampled mid-high, well after the slave's synchronised drive
   task automatic get_bit(output logic b);
      #80 sda_low = 1'b0;
      #80 scl_low = 1'b0;
      #80 b = sda_in;
      #80 scl_low = 1'b1;
   endtask : get_bit

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(a);
      ack = ~a;
   endtask : write_byte

   task automatic read_byte(input logic nack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(nack);
   endtask : read_byte
endmodule : twowire_bus_master

// ==== tb/twowire_sw_master_hw_slave_bench.sv ====
// Self-checking bench for the two-wire block: register port tasks,
// software-master pin checks and slave transfers against a bus model.
// Assumes pull-ups on both lines and a 25 MHz core clock.
`timescale 1ns/1ps
module twowire_sw_master_hw_slave_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic spi_select_bit = 1'b0;
   logic sda_out, sda_oe, scl_out, scl_oe, m_sda_low, m_scl_low;
   logic sda_w, scl_w, ack;
   logic [7:0] rd;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   // Wired-AND of both parties with pull-up
   assign sda_w = ~m_sda_low & (~sda_oe | sda_out);
   assign scl_w = ~m_scl_low & (~scl_oe | scl_out);

   twowire_core dut_u (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .spi_select_bit(spi_select_bit),
      .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
      .serial_clock_pin_in(scl_w), .serial_clock_pin_out(scl_out), .serial_clock_pin_oe(scl_oe));

   twowire_bus_master m_u (.sda_in(sda_w), .scl_in(scl_w), .sda_low(m_sda_low), .scl_low(m_scl_low));

   initial begin
      forever #20 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(posedge clk);
      #1 d = sfr_rdata;
   endtask : reg_rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      reg_rd(a, v);
      check(v, exp);
   endtask : rd_chk

   task automatic pins_chk(input logic [3:0] exp);
      @(posedge clk);
      #1 check({4'h0, sda_oe, sda_out, scl_oe, scl_out}, {4'h0, exp});
   endtask : pins_chk

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'he8, 8'h00);
      rd_chk(8'h9b, 8'h55);
      rd_chk(8'h9a, 8'h00);
      rd_chk(8'h3c, 8'h00);
      reg_wr(8'h9b, 8'h42);
      rd_chk(8'h9b, 8'h42);
      end_test("reset_values");

      // Pin order: data oe, data out, clock oe, clock out
      reg_wr(8'he8, 8'h68);
      pins_chk(4'b1011);
      reg_wr(8'he8, 8'hc8);
      pins_chk(4'b1110);
      reg_wr(8'he8, 8'h88);
      pins_chk(4'b0110);
      reg_wr(8'he8, 8'h28);
      pins_chk(4'b0011);
      @(posedge clk);
      spi_select_bit <= 1'b1;
      // Released clock pin still shows its idle high value
      pins_chk(4'b0001);
      @(posedge clk);
      spi_select_bit <= 1'b0;
      end_test("master_pins");

      reg_wr(8'he8, 8'h08);
      m_u.hold_data(1'b0);
      reg_wr(8'he8, 8'h28);
      repeat (6) @(posedge clk);
      rd_chk(8'he8, 8'h28);
      m_u.hold_data(1'b1);
      reg_wr(8'he8, 8'h08);
      reg_wr(8'he8, 8'h28);
      repeat (6) @(posedge clk);
      rd_chk(8'he8, 8'h38);
      end_test("master_sample");

      reg_wr(8'he8, 8'h00);
      m_u.start_bit();
      m_u.write_byte(8'h84, ack);
      check({7'h00, ack}, 8'h01);
      m_u.write_byte(8'ha5, ack);
      check({7'h00, ack}, 8'h01);
      m_u.stop_bit();
      // Bit 4 keeps the last master sample, a one
      rd_chk(8'he8, 8'h11);
      // One data access per byte event
      rd_chk(8'h9a, 8'ha5);
      reg_wr(8'he8, 8'h00);
      rd_chk(8'he8, 8'h10);
      end_test("slave_receive");

      m_u.start_bit();
      m_u.write_byte(8'h86, ack);
      check({7'h00, ack}, 8'h00);
      m_u.stop_bit();
      rd_chk(8'he8, 8'h10);
      end_test("slave_mismatch");

      reg_wr(8'h9a, 8'h3c);
      m_u.start_bit();
      m_u.write_byte(8'h85, ack);
      check({7'h00, ack}, 8'h01);
      rd_chk(8'he8, 8'h12);
      // Acknowledged byte, then a reload of the same data for the last one
      m_u.read_byte(1'b0, rd);
      check(rd, 8'h3c);
      m_u.read_byte(1'b1, rd);
      check(rd, 8'h3c);
      m_u.stop_bit();
      rd_chk(8'he8, 8'h11);
      end_test("slave_transmit");

      reg_wr(8'he8, 8'h04);
      m_u.start_bit();
      m_u.write_byte(8'h84, ack);
      check({7'h00, ack}, 8'h00);
      m_u.stop_bit();
      rd_chk(8'he8, 8'h14);
      reg_wr(8'he8, 8'h00);
      m_u.start_bit();
      m_u.write_byte(8'h84, ack);
      check({7'h00, ack}, 8'h01);
      m_u.stop_bit();
      end_test("slave_reset");
      wrap_up();
   end
endmodule : twowire_sw_master_hw_slave_bench
